/* rti_core.sv */
// The AHB-Lite slave port and the register offsets are this design's own decisions.
`timescale 1ns/1ps
// How it works
// RL1 - Mode 0: assert when speed at/above threshold
// RL2 - Mode 0: deassert when speed below threshold
// RL3 - Indicator output is active low
// RL4 - Mode 1: assert when torque reaches limit
// RL5 - Mode 1: deassert when torque below limit
// RL6 - Compare against forward and reverse torque limits
// RL7 - Limit-select inputs pick external current limits
// RL8 - Status bit and monitor bit 4 mirror indicator
// RL9 - Threshold range 1 to max speed, default 20
// RL10 - Function switch bit 4 selects mode, default 0
// RL11 - Limit-select inputs active when driven low
// RL12 - Comparison registered every clock cycle
module rti_core
   import rti_pkg::*;
#(
   parameter int DW = 16,
   parameter logic [15:0] MAX_SPEED = RTI_SPD_MAX_DEF
) (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   input wire logic [DW-1:0] motor_speed,
   input wire logic signed [DW-1:0] torque_ref,
   input wire logic forward_limit_select_in,
   input wire logic reverse_limit_select_in,
   output logic running_indicator_out,
   output logic status_running_bit,
   output logic [15:0] io_monitor_word
);

   // ****************************************************************
   // Bus slave
   // ****************************************************************

   // Settings that software writes; they keep their value until reset.
   logic [15:0] function_switch_word_q;
   logic [15:0] zero_speed_threshold_q;
   logic [15:0] forward_torque_limit_q;
   logic [15:0] reverse_torque_limit_q;
   logic [15:0] forward_external_current_limit_q;
   logic [15:0] reverse_external_current_limit_q;
   // Address phase held over into the data phase.
   logic wr_pend_q;
   logic rd_pend_q;
   logic [7:0] addr_q;
   // Indicator datapath.
   logic ind_q;
   logic mode_trq;
   logic [15:0] abs_trq;
   logic [15:0] act_lim;
   logic ind_d;
   rti_lim_sel_t lim_sel;
   logic [15:0] wval;

   // Address phase capture; the slave is always ready, so hready alone gates it.
   // The transfer size is not decoded: every register is one aligned word, and
   // narrower accesses simply act on the whole word.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend_q <= 1'b0;
         rd_pend_q <= 1'b0;
         addr_q <= 8'h00;
      end else if (hready) begin
         wr_pend_q <= hsel && htrans[1] && hwrite;
         rd_pend_q <= hsel && htrans[1] && !hwrite;
         addr_q <= haddr[7:0];
      end
   end

   // Only the low half of the data bus carries register contents.
   assign wval = hwdata[15:0];

   // ****************************************************************
   // Configuration registers
   // ****************************************************************

   // Configuration writes. The threshold is clamped into its legal range so that
   // software can never program a zero or over-speed level.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         function_switch_word_q <= RTI_FUNC_SW_RST; // RL10
         zero_speed_threshold_q <= RTI_ZERO_SPD_RST; // RL9
         forward_torque_limit_q <= RTI_TLIM_RST;
         reverse_torque_limit_q <= RTI_TLIM_RST;
         forward_external_current_limit_q <= RTI_TLIM_RST;
         reverse_external_current_limit_q <= RTI_TLIM_RST;
      end else if (wr_pend_q) begin
         case (addr_q)
            RTI_FUNC_SW_OFS: function_switch_word_q <= wval;
            RTI_ZERO_SPD_OFS: begin
               if (wval < RTI_ZERO_SPD_MIN) begin
                  zero_speed_threshold_q <= RTI_ZERO_SPD_MIN; // RL9
               end else if (wval > MAX_SPEED) begin
                  zero_speed_threshold_q <= MAX_SPEED; // RL9
               end else begin
                  zero_speed_threshold_q <= wval;
               end
            end
            RTI_FWD_TLIM_OFS: forward_torque_limit_q <= wval;
            RTI_REV_TLIM_OFS: reverse_torque_limit_q <= wval;
            RTI_FWD_EXT_OFS: forward_external_current_limit_q <= wval;
            RTI_REV_EXT_OFS: reverse_external_current_limit_q <= wval;
            default: ;
         endcase
      end
   end

   // ****************************************************************
   // Read-back path
   // ****************************************************************

   // Read data is registered so that it stands during the data phase.
   // Live inputs are sampled at the address phase, so a read shows the speed
   // and torque that stood one cycle before the data phase ends.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata <= 32'h00000000;
      end else if (hready && hsel && htrans[1] && !hwrite) begin
         case (haddr[7:0])
            RTI_FUNC_SW_OFS: hrdata <= {16'h0000, function_switch_word_q};
            RTI_ZERO_SPD_OFS: hrdata <= {16'h0000, zero_speed_threshold_q};
            RTI_FWD_TLIM_OFS: hrdata <= {16'h0000, forward_torque_limit_q};
            RTI_REV_TLIM_OFS: hrdata <= {16'h0000, reverse_torque_limit_q};
            RTI_FWD_EXT_OFS: hrdata <= {16'h0000, forward_external_current_limit_q};
            RTI_REV_EXT_OFS: hrdata <= {16'h0000, reverse_external_current_limit_q};
            RTI_SPEED_OFS: hrdata <= {{(32-DW){1'b0}}, motor_speed};
            RTI_TORQUE_OFS: hrdata <= {{(32-DW){torque_ref[DW-1]}}, torque_ref};
            RTI_STATUS_OFS: hrdata <= {31'h00000000, ind_q};
            RTI_MONITOR_OFS: hrdata <= {16'h0000, io_monitor_word};
            default: hrdata <= 32'h00000000;
         endcase
      end
   end

   // ****************************************************************
   // Bus response
   // ****************************************************************

   // Zero wait states and an OKAY response on every access.
   // Nothing here can fail, so an error response would only confuse the host.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end else begin
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end
   end

   // ****************************************************************
   // Indicator logic
   // ****************************************************************

   // Torque magnitude is compared so one limit covers each direction.
   assign mode_trq = function_switch_word_q[RTI_MODE_BIT]; // RL10
   assign abs_trq = torque_ref[DW-1] ? 16'(-torque_ref) : 16'(torque_ref);

   // ****************************************************************
   // Limit selection
   // ****************************************************************

   // Limit selection: low-active select inputs take precedence over the
   // internal limits; forward wins if both are driven at once.
   always_comb begin
      if (!forward_limit_select_in) begin // RL11
         lim_sel = RTI_LIM_FEXT; // RL7
      end else if (!reverse_limit_select_in) begin // RL11
         lim_sel = RTI_LIM_REXT; // RL7
      end else if (torque_ref[DW-1]) begin
         lim_sel = RTI_LIM_REV; // RL6
      end else begin
         lim_sel = RTI_LIM_FWD; // RL6
      end
      case (lim_sel)
         RTI_LIM_FWD: act_lim = forward_torque_limit_q;
         RTI_LIM_REV: act_lim = reverse_torque_limit_q;
         RTI_LIM_FEXT: act_lim = forward_external_current_limit_q;
         RTI_LIM_REXT: act_lim = reverse_external_current_limit_q;
         default: act_lim = forward_torque_limit_q;
      endcase
   end

   // Mode compare: speed against threshold, or torque against active limit.
   // Both comparisons include equality, so a value sitting on the limit counts.
   always_comb begin
      if (mode_trq) begin
         ind_d = abs_trq >= act_lim; // RL4 RL5
      end else begin
         ind_d = motor_speed >= zero_speed_threshold_q; // RL1 RL2
      end
   end

   // ****************************************************************
   // Output registers
   // ****************************************************************

   // Separate registers drive the pin and both mirrors, all loaded from ind_d, so they never disagree.
   // The pin is inverted from the same next value rather than from ind_q, so the
   // contact and the status bits change on the very same clock edge.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ind_q <= 1'b0;
         running_indicator_out <= 1'b1;
         status_running_bit <= 1'b0;
         io_monitor_word <= 16'h0000;
      end else begin
         ind_q <= ind_d; // RL12
         running_indicator_out <= !ind_d; // RL3
         status_running_bit <= ind_d; // RL8
         io_monitor_word <= 16'(ind_d) << RTI_MON_BIT; // RL8
      end
   end

   // ****************************************************************
   // Assertions
   // ****************************************************************
   // Mode 0: the indicator follows speed against the zero-speed threshold.
   a_run_mode_on: assert property (@(posedge hclk) disable iff (!hresetn) // RL1
      !mode_trq && motor_speed >= zero_speed_threshold_q
      |=> !running_indicator_out)
      else $error("indicator not asserted at speed");
   a_run_mode_off: assert property (@(posedge hclk) disable iff (!hresetn) // RL2
      !mode_trq && motor_speed < zero_speed_threshold_q |=> running_indicator_out)
      else $error("indicator asserted below threshold");

   // The pin and the status bit are always opposite in level.
   a_pin_low_active: assert property (@(posedge hclk) disable iff (!hresetn) // RL3
      running_indicator_out == !status_running_bit)
      else $error("pin polarity wrong");
   a_pin_follows_ind: assert property (@(posedge hclk) disable iff (!hresetn) // RL3 RL12
      running_indicator_out == !ind_q)
      else $error("pin and indicator register disagree");

   // Mode 1: the indicator follows torque magnitude against the active limit.
   a_trq_mode_on: assert property (@(posedge hclk) disable iff (!hresetn) // RL4
      mode_trq && abs_trq >= act_lim |=> !running_indicator_out)
      else $error("torque limit not indicated");
   a_trq_mode_off: assert property (@(posedge hclk) disable iff (!hresetn) // RL5
      mode_trq && abs_trq < act_lim |=> running_indicator_out)
      else $error("torque indication while below limit");

   // Limit choice for each combination of the select inputs.
   a_lim_internal: assert property (@(posedge hclk) disable iff (!hresetn) // RL6
      forward_limit_select_in && reverse_limit_select_in
      |-> act_lim == (torque_ref[DW-1] ? reverse_torque_limit_q : forward_torque_limit_q))
      else $error("internal limit chosen wrongly");
   a_lim_external: assert property (@(posedge hclk) disable iff (!hresetn) // RL7 RL11
      !forward_limit_select_in |-> act_lim == forward_external_current_limit_q)
      else $error("external limit not used");
   a_lim_rev_ext: assert property (@(posedge hclk) disable iff (!hresetn) // RL7 RL11
      forward_limit_select_in && !reverse_limit_select_in
      |-> act_lim == reverse_external_current_limit_q)
      else $error("reverse external limit not used");

   // Mirrors: the monitor word carries the indicator in one bit only.
   a_mon_mirror: assert property (@(posedge hclk) disable iff (!hresetn) // RL8
      io_monitor_word[RTI_MON_BIT] == status_running_bit && status_running_bit == ind_q)
      else $error("monitor mirror mismatch");
   a_mon_other_zero: assert property (@(posedge hclk) disable iff (!hresetn) // RL8
      (io_monitor_word & ~(16'h0001 << RTI_MON_BIT)) == 16'h0000)
      else $error("monitor word carries stray bits");

   // Software settings land as written, or clamped into the legal range.
   a_thr_range: assert property (@(posedge hclk) disable iff (!hresetn) // RL9
      zero_speed_threshold_q >= RTI_ZERO_SPD_MIN && zero_speed_threshold_q <= MAX_SPEED)
      else $error("threshold out of range");
   a_thr_write_lands: assert property (@(posedge hclk) disable iff (!hresetn) // RL9
      wr_pend_q && addr_q == RTI_ZERO_SPD_OFS && wval >= RTI_ZERO_SPD_MIN && wval <= MAX_SPEED
      |=> zero_speed_threshold_q == $past(wval))
      else $error("legal threshold write lost");
   a_thr_clamp_low: assert property (@(posedge hclk) disable iff (!hresetn) // RL9
      wr_pend_q && addr_q == RTI_ZERO_SPD_OFS && wval < RTI_ZERO_SPD_MIN
      |=> zero_speed_threshold_q == RTI_ZERO_SPD_MIN)
      else $error("zero threshold not clamped");
   a_thr_clamp_high: assert property (@(posedge hclk) disable iff (!hresetn) // RL9
      wr_pend_q && addr_q == RTI_ZERO_SPD_OFS && wval > MAX_SPEED
      |=> zero_speed_threshold_q == MAX_SPEED)
      else $error("over-speed threshold not clamped");
   a_mode_write: assert property (@(posedge hclk) disable iff (!hresetn) // RL10
      wr_pend_q && addr_q == RTI_FUNC_SW_OFS |=> mode_trq == $past(wval[RTI_MODE_BIT]))
      else $error("mode bit write lost");

   // One cycle of latency from inputs to the registered outputs.
   a_ind_registered: assert property (@(posedge hclk) disable iff (!hresetn) // RL12
      status_running_bit == $past(ind_d))
      else $error("indicator not updated each cycle");

   // Bus side: reads of the mirrors return what the outputs showed.
   a_rd_status_bit: assert property (@(posedge hclk) disable iff (!hresetn) // RL8
      rd_pend_q && addr_q == RTI_STATUS_OFS |-> hrdata == {31'h00000000, $past(ind_q)})
      else $error("status read does not match indicator");
   a_rd_monitor_word: assert property (@(posedge hclk) disable iff (!hresetn) // RL8
      rd_pend_q && addr_q == RTI_MONITOR_OFS |-> hrdata == {16'h0000, $past(io_monitor_word)})
      else $error("monitor read does not match monitor word");
   a_bus_okay: assert property (@(posedge hclk) disable iff (!hresetn)
      hreadyout && !hresp)
      else $error("bus response not ready or not okay");

endmodule : rti_core

/* rti_pkg.sv */
package rti_pkg;

   // ****************************************************************
   // Register map (byte addresses on the AHB-Lite bus)
   // ****************************************************************
   localparam logic [7:0] RTI_FUNC_SW_OFS = 8'h00;
   localparam logic [7:0] RTI_ZERO_SPD_OFS = 8'h04;
   localparam logic [7:0] RTI_FWD_TLIM_OFS = 8'h08;
   localparam logic [7:0] RTI_REV_TLIM_OFS = 8'h0C;
   localparam logic [7:0] RTI_FWD_EXT_OFS = 8'h10;
   localparam logic [7:0] RTI_REV_EXT_OFS = 8'h14;
   localparam logic [7:0] RTI_SPEED_OFS = 8'h18;
   localparam logic [7:0] RTI_TORQUE_OFS = 8'h1C;
   localparam logic [7:0] RTI_STATUS_OFS = 8'h20;
   localparam logic [7:0] RTI_MONITOR_OFS = 8'h24;

   // ****************************************************************
   // Field positions and reset values
   // ****************************************************************
   localparam int RTI_MODE_BIT = 4;
   localparam int RTI_MON_BIT = 4;
   localparam logic [15:0] RTI_ZERO_SPD_RST = 16'h0014;
   localparam logic [15:0] RTI_ZERO_SPD_MIN = 16'h0001;
   localparam logic [15:0] RTI_SPD_MAX_DEF = 16'h1770;
   localparam logic [15:0] RTI_TLIM_RST = 16'h7FFF;
   localparam logic [15:0] RTI_FUNC_SW_RST = 16'h0000;

   // Selection of the active torque limit.
   typedef enum logic [1:0] {
      RTI_LIM_FWD = 2'b00,
      RTI_LIM_REV = 2'b01,
      RTI_LIM_FEXT = 2'b10,
      RTI_LIM_REXT = 2'b11
   } rti_lim_sel_t;

endpackage : rti_pkg

/* rti_host_model.sv */
`timescale 1ns/1ps
// ****************************************************************
// Host controller that reads the indicator contact as an interlock
// ****************************************************************
module rti_host_model (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic running_indicator_out,
   output logic interlock_q
);
   // The contact is closed when the pin is low, so the host sees the indication there.
   // The input stage adds one register, as a real opto-coupled input would.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         interlock_q <= 1'b0;
      end else begin
         interlock_q <= !running_indicator_out;
      end
   end
endmodule : rti_host_model

/* testbench.sv */
`timescale 1ns/1ps
module testbench;
   import rti_pkg::*;
   logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, ind_n, stat_bit, interlock, fwd_sel_n, rev_sel_n;
   logic [31:0] haddr, hwdata, hrdata, seed, r;
   logic [1:0] htrans;
   logic [15:0] motor_speed, io_monitor_word;
   logic signed [15:0] torque_ref;
   int error_cnt, total_checks, thr, mode, i, j;
   int lim[$];
   int tv[10] = '{79, 80, 127, 128, 255, 256, -511, -512, -513, 0};

   rti_core u_rti_core (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp), .motor_speed(motor_speed), .torque_ref(torque_ref),
      .forward_limit_select_in(fwd_sel_n), .reverse_limit_select_in(rev_sel_n),
      .running_indicator_out(ind_n), .status_running_bit(stat_bit), .io_monitor_word(io_monitor_word));
   rti_host_model u_rti_host_model (.hclk(hclk), .hresetn(hresetn), .running_indicator_out(ind_n),
      .interlock_q(interlock));

   // Free-running 50 MHz clock.
   initial begin
      hclk = 1'b0;
      forever #10 hclk = ~hclk;
   end

   // ****************************************************************
   // Reporting, bus master and reference model
   // ****************************************************************
   task results;
      if (error_cnt == 0 && total_checks > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask : results

   task cmp_reg(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("mismatch at %0t: word %h expected %h", $time, got, exp);
      end
   endtask : cmp_reg

   task cmp_pin(input logic [2:0] got, input logic [2:0] exp);
      total_checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("mismatch at %0t: pin/status/interlock %b expected %b", $time, got, exp);
      end
   endtask : cmp_pin

   // Bounded wait for hready; a hang ends the run instead of stalling it.
   task wait_rdy;
      int k;
      k = 0;
      do begin
         @(posedge hclk);
         k++;
      end while (hreadyout !== 1'b1 && k < 50);
      if (hreadyout !== 1'b1) begin
         error_cnt++;
         $display("mismatch at %0t: bus never ready", $time);
         results();
      end
   endtask : wait_rdy

   // One single word transfer; entered right after a rising edge.
   task bus(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
      hsel <= 1'b1;
      haddr <= {24'h000000, a};
      htrans <= 2'b10;
      hwrite <= wr;
      wait_rdy();
      htrans <= 2'b00;
      hwdata <= wd;
      wait_rdy();
      rd = hrdata;
      cmp_reg({31'h00000000, hresp}, 32'h00000000);
   endtask : bus

   task rd_chk(input logic [7:0] a, input logic [31:0] exp);
      bus(1'b0, a, 32'h00000000, r);
      cmp_reg(r, exp);
   endtask : rd_chk

   // Indication expected from the present inputs and the values software wrote.
   function automatic logic exp_on(int spd, int tq);
      int l;
      if (mode == 0) return spd >= thr;
      l = !fwd_sel_n ? lim[2] : !rev_sel_n ? lim[3] : tq >= 0 ? lim[0] : lim[1];
      return (tq < 0 ? -tq : tq) >= l;
   endfunction : exp_on

   function automatic logic [31:0] lfsr(logic [31:0] x);
      return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
   endfunction : lfsr

   // Inputs settle for two edges: one for the design register, one for the host stage.
   task apply(input int spd, input int tq, input logic f, input logic rv);
      logic e;
      motor_speed <= spd[15:0];
      torque_ref <= tq[15:0];
      fwd_sel_n <= f;
      rev_sel_n <= rv;
      @(posedge hclk);
      @(posedge hclk);
      #1;
      e = exp_on(spd, tq);
      cmp_pin({ind_n, stat_bit, interlock}, {!e, e, e});
      cmp_reg({16'h0000, io_monitor_word}, {27'h0000000, e, 4'h0});
      @(posedge hclk);
      rd_chk(RTI_STATUS_OFS, {31'h00000000, e});
      rd_chk(RTI_MONITOR_OFS, {27'h0000000, e, 4'h0});
      rd_chk(RTI_SPEED_OFS, 32'(spd));
      rd_chk(RTI_TORQUE_OFS, 32'(tq));
   endtask : apply

   // ****************************************************************
   // Main sequence
   // ****************************************************************
   initial begin
      hresetn = 1'b0;
      hsel = 1'b0;
      haddr = 32'h00000000;
      htrans = 2'b00;
      hwrite = 1'b0;
      hwdata = 32'h00000000;
      motor_speed = 16'h0000;
      torque_ref = 16'sh0000;
      fwd_sel_n = 1'b1;
      rev_sel_n = 1'b1;
      seed = 32'd71067;
      mode = 0;
      thr = 20;
      error_cnt = 0;
      total_checks = 0;
      repeat (8) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      rd_chk(RTI_FUNC_SW_OFS, 32'h00000000);
      rd_chk(RTI_ZERO_SPD_OFS, 32'h00000014);
      for (i = 0; i < 4; i++) rd_chk(RTI_FWD_TLIM_OFS + 8'(4 * i), 32'h00007FFF);
      rd_chk(8'h40, 32'h00000000);
      bus(1'b1, RTI_ZERO_SPD_OFS, 32'h00000000, r);
      rd_chk(RTI_ZERO_SPD_OFS, 32'h00000001);
      bus(1'b1, RTI_ZERO_SPD_OFS, 32'h0000FFFF, r);
      rd_chk(RTI_ZERO_SPD_OFS, {16'h0000, RTI_SPD_MAX_DEF});
      bus(1'b1, RTI_ZERO_SPD_OFS, 32'(thr), r);
      rd_chk(RTI_ZERO_SPD_OFS, 32'(thr));
      for (i = 18; i < 23; i++) apply(i, 0, 1'b1, 1'b1);
      thr = 300;
      bus(1'b1, RTI_ZERO_SPD_OFS, 32'(thr), r);
      for (i = 0; i < 12; i++) begin
         seed = lfsr(seed);
         apply(i < 4 ? thr - 2 + i : int'(seed[9:0]), 0, 1'b1, 1'b1);
      end
      bus(1'b1, RTI_FUNC_SW_OFS, 32'h00000010, r);
      mode = 1;
      lim = '{256, 512, 80, 128};
      for (i = 0; i < 4; i++) bus(1'b1, RTI_FWD_TLIM_OFS + 8'(4 * i), 32'(lim[i]), r);
      rd_chk(RTI_FUNC_SW_OFS, 32'h00000010);
      for (i = 0; i < 4; i++) rd_chk(RTI_FWD_TLIM_OFS + 8'(4 * i), 32'(lim[i]));
      for (j = 0; j < 4; j++) begin
         for (i = 0; i < 13; i++) begin
            seed = lfsr(seed);
            apply(0, i < 10 ? tv[i] : int'(seed[10:0]) - 1024, j[0], j[1]);
         end
      end
      results();
   end
endmodule : testbench
